// *** core/cft_bpar.sv ***
// Byte parity generator
`timescale 1ns/1ns
`default_nettype none
module cft_bpar #(
  parameter int BYTES = 4
) (
  input wire logic [8*BYTES-1:0] data,
  output logic [BYTES-1:0] par
);
  genvar b;
  generate
    for (b = 0; b < BYTES; b++) begin : g_byte
      assign par[b] = ^data[8*b +: 8];
    end
  endgenerate
endmodule // cft_bpar
`default_nettype wire

// *** core/cft_front.sv ***
// Translation buffer, physical cache and instruction prefetch buffer
`timescale 1ns/1ns
`default_nettype none
`include "cft_map.svh"
// Behaviour
// - 8 KB two-way set associative cache holds all memory-sourced data
// - Miss fetches an eight-byte block, forwards four bytes to requester
// - Other four bytes of the block stay resident for later hits
// - One parity bit per byte on cached data and tags, checked on read
// - Entries are allocated only by memory read fills
// - With both ways valid the victim way is picked at random
// - Translation buffer holds 128 entries, half system, half process space
// - Each half is two-way and looked up by the address space bit
// - Byte parity on each translation entry, checked when read
// - Virtual address is translated first, then the cache is searched physically
// - Eight-byte prefetch buffer refills sequentially when four bytes fit and no data read waits, until a prefetch translation miss or parity error stalls it
// - Instruction bytes across longword boundaries come out in one answer
// - Next opcode or specifier bytes handed to execution unit on request
// - Taken branch flushes buffer, loads target, restarts prefetch there
// - New miss waits until the outstanding memory read has completed
// - Unwanted prefetch data is installed in cache, not into the buffer
module cft_front
  import cft_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic dp_req_valid,
  input wire logic [31:0] dp_req_vaddr,
  output logic dp_req_ready,
  output var cft_dp_rsp_t dp_rsp,
  input wire logic ib_req,
  input wire logic [`CFT_LEN_W-1:0] ib_req_len,
  output logic ib_rsp_valid,
  output logic [31:0] ib_rsp_data,
  output logic [`CFT_IB_CNT_W-1:0] ib_level,
  input wire logic br_valid,
  input wire logic [31:0] br_target,
  input wire logic tb_wr_valid,
  input wire logic [31:0] tb_wr_vaddr,
  input wire logic [`CFT_PFN_W-1:0] tb_wr_pfn,
  output logic mem_rd_valid,
  output logic [31:0] mem_rd_addr,
  input wire logic mem_rsp_valid,
  input wire logic [`CFT_LINE_W-1:0] mem_rsp_data,
  output logic pf_tb_miss,
  output logic par_err
);
  cft_state_t state_reg, state_next;
  logic req_pf_reg, req_pf_next;
  logic squash_reg, squash_next;
  logic [31:0] vaddr_reg, vaddr_next;
  logic [31:0] paddr_reg, paddr_next;
  logic [`CFT_SET_W-1:0] init_reg, init_next;
  logic [7:0] lfsr_reg, lfsr_next;
  logic vict_reg, vict_next;
  logic out_reg, out_next;
  logic mrv_reg, mrv_next;
  logic [31:0] mra_reg, mra_next;
  logic rdy_reg, rdy_next;
  cft_dp_rsp_t rsp_reg, rsp_next;
  logic [63:0] ibb_reg, ibb_next;
  logic [`CFT_IB_CNT_W-1:0] ibc_reg, ibc_next;
  logic ibv_reg, ibv_next;
  logic [31:0] ibd_reg, ibd_next;
  logic [31:0] pfa_reg, pfa_next;
  logic [1:0] pfo_reg, pfo_next;
  logic stall_reg, stall_next;
  logic pfm_reg, pfm_next;
  logic perr_reg, perr_next;

  cft_tentry_t tb_rd [2];
  cft_centry_t c_rd [2];
  logic [`CFT_TPAR_W-1:0] tb_chk [2];
  logic [`CFT_CPAR_W-1:0] c_chk [2];
  logic [1:0] tb_hit, tb_perr, c_hit, c_perr, tb_we, c_we;
  logic tb_re, c_re, fill_en;
  logic [`CFT_TB_AW-1:0] tb_ra, tb_wa;
  logic [`CFT_SET_W-1:0] c_wa;
  logic [`CFT_TPAR_W-1:0] tb_wpar;
  logic [`CFT_CPAR_W-1:0] c_wpar;
  logic [`CFT_TAG_W-1:0] ftag;
  cft_tentry_t tb_wd;
  cft_centry_t c_wd;
  logic [31:0] fill_lw, hit_lw;

  assign ftag = `CFT_TAG_W'(paddr_reg[31:`CFT_TAG_LO]);
  cft_bpar #(.BYTES(`CFT_TPAR_W)) u_tb_wpar (
    .data({tb_wr_vaddr[`CFT_TB_TAG_HI:`CFT_TB_TAG_LO], tb_wr_pfn}),
    .par(tb_wpar)
  );
  cft_bpar #(.BYTES(`CFT_CPAR_W)) u_c_wpar (
    .data({ftag, mem_rsp_data}),
    .par(c_wpar)
  );

  genvar w;
  generate
    for (w = 0; w < 2; w++) begin : g_way
      cft_ram #(.WIDTH($bits(cft_tentry_t)), .DEPTH(`CFT_TB_DEPTH), .AW(`CFT_TB_AW)) u_tb (
        .clock(clock), .resetn(resetn), .rd_en(tb_re), .rd_addr(tb_ra), .rd_data(tb_rd[w]),
        .wr_en(tb_we[w]), .wr_addr(tb_wa), .wr_data(tb_wd)
      );
      cft_ram #(.WIDTH($bits(cft_centry_t)), .DEPTH(`CFT_SETS), .AW(`CFT_SET_W)) u_c (
        .clock(clock), .resetn(resetn), .rd_en(c_re), .rd_addr(paddr_next[`CFT_IDX_HI:`CFT_IDX_LO]),
        .rd_data(c_rd[w]), .wr_en(c_we[w]), .wr_addr(c_wa), .wr_data(c_wd)
      );
      cft_bpar #(.BYTES(`CFT_TPAR_W)) u_tchk (.data({tb_rd[w].vtag, tb_rd[w].pfn}), .par(tb_chk[w]));
      cft_bpar #(.BYTES(`CFT_CPAR_W)) u_cchk (.data({c_rd[w].tag, c_rd[w].data}), .par(c_chk[w]));
      assign tb_perr[w] = tb_rd[w].valid && (tb_chk[w] != tb_rd[w].par);
      assign tb_hit[w] = tb_rd[w].valid && (tb_rd[w].vtag == vaddr_reg[`CFT_TB_TAG_HI:`CFT_TB_TAG_LO]);
      assign c_perr[w] = c_rd[w].valid && (c_chk[w] != c_rd[w].par);
      assign c_hit[w] = c_rd[w].valid && (c_rd[w].tag == ftag);
    end
  endgenerate

  // Write side of both arrays
  always_comb begin
    tb_we = 2'h0;
    c_we = 2'h0;
    tb_wa = {tb_wr_vaddr[`CFT_SPACE_BIT], tb_wr_vaddr[`CFT_TB_IDX_HI:`CFT_TB_IDX_LO]};
    tb_wd = cft_tentry_t'({1'b1, tb_wpar, tb_wr_vaddr[`CFT_TB_TAG_HI:`CFT_TB_TAG_LO], tb_wr_pfn});
    c_wa = paddr_reg[`CFT_IDX_HI:`CFT_IDX_LO];
    c_wd = cft_centry_t'({1'b1, c_wpar, ftag, mem_rsp_data});
    if (state_reg == ST_INIT) begin
      tb_wa = init_reg[`CFT_TB_AW-1:0];
      tb_wd = '0;
      tb_we = (32'(init_reg) < `CFT_TB_DEPTH) ? 2'h3 : 2'h0;
      c_wa = init_reg;
      c_wd = '0;
      c_we = 2'h3;
    end else begin
      if (tb_wr_valid) begin
        tb_we = lfsr_reg[1] ? 2'h2 : 2'h1;
      end
      if (state_reg == ST_MEM && mem_rsp_valid) begin
        c_we = vict_reg ? 2'h2 : 2'h1;
      end
    end
  end

  assign fill_lw = paddr_reg[`CFT_WSEL_BIT] ? mem_rsp_data[63:32] : mem_rsp_data[31:0];
  assign hit_lw = c_hit[1] ? (paddr_reg[`CFT_WSEL_BIT] ? c_rd[1].data[63:32] : c_rd[1].data[31:0])
                           : (paddr_reg[`CFT_WSEL_BIT] ? c_rd[0].data[63:32] : c_rd[0].data[31:0]);

  // Next state of sequencer and prefetch buffer
  always_comb begin
    int cnt_i;
    int off_i;
    int nb_i;
    logic [31:0] lw;
    logic deliver;
    logic [31:0] dlw;
    cnt_i = 32'(ibc_reg);
    off_i = 32'(pfo_reg);
    nb_i = 0;
    lw = 32'h0;
    deliver = 1'b0;
    dlw = 32'h0;
    state_next = state_reg;
    req_pf_next = req_pf_reg;
    squash_next = squash_reg;
    vaddr_next = vaddr_reg;
    paddr_next = paddr_reg;
    init_next = init_reg;
    lfsr_next = {lfsr_reg[6:0], ^(lfsr_reg & `CFT_LFSR_TAPS)};
    vict_next = vict_reg;
    out_next = out_reg;
    mrv_next = 1'b0;
    mra_next = mra_reg;
    rsp_next = '0;
    ibb_next = ibb_reg;
    ibv_next = 1'b0;
    ibd_next = ibd_reg;
    pfa_next = pfa_reg;
    pfo_next = pfo_reg;
    stall_next = stall_reg;
    pfm_next = 1'b0;
    perr_next = 1'b0;
    tb_re = 1'b0;
    tb_ra = {vaddr_reg[`CFT_SPACE_BIT], vaddr_reg[`CFT_TB_IDX_HI:`CFT_TB_IDX_LO]};
    c_re = 1'b0;
    fill_en = 1'b0;
    // Hand bytes from the head, spanning longwords
    if (ib_req && ib_req_len != 3'h0 && 32'(ib_req_len) <= `CFT_LW_BYTES && 32'(ib_req_len) <= cnt_i) begin
      ibv_next = 1'b1;
      ibd_next = ibb_reg[31:0];
      ibb_next = ibb_reg >> {ib_req_len, 3'h0};
      cnt_i = cnt_i - 32'(ib_req_len);
    end
    case (state_reg)
      ST_INIT: begin
        init_next = init_reg + 9'h001;
        if (init_reg == 9'(`CFT_SETS - 1)) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (dp_req_valid) begin
          vaddr_next = dp_req_vaddr;
          req_pf_next = 1'b0;
          state_next = ST_TB;
        end else if (!stall_reg && !br_valid && 32'(ibc_reg) <= `CFT_IB_BYTES - `CFT_LW_BYTES) begin
          vaddr_next = pfa_reg;
          req_pf_next = 1'b1;
          squash_next = 1'b0;
          state_next = ST_TB;
        end
        tb_re = state_next == ST_TB;
        tb_ra = {vaddr_next[`CFT_SPACE_BIT], vaddr_next[`CFT_TB_IDX_HI:`CFT_TB_IDX_LO]};
      end
      ST_TB: begin
        state_next = ST_IDLE;
        if (|tb_perr) begin
          perr_next = 1'b1;
          rsp_next.valid = !req_pf_reg;
          rsp_next.par_err = 1'b1;
          stall_next = req_pf_reg && !squash_reg;
        end else if (|tb_hit) begin
          paddr_next = {tb_hit[1] ? tb_rd[1].pfn : tb_rd[0].pfn, vaddr_reg[`CFT_PG_HI:0]};
          c_re = 1'b1;
          state_next = ST_CA;
        end else begin
          rsp_next.valid = !req_pf_reg;
          rsp_next.tb_miss = 1'b1;
          pfm_next = req_pf_reg && !squash_reg;
          stall_next = req_pf_reg && !squash_reg;
        end
      end
      ST_CA: begin
        if (|c_perr) begin
          perr_next = 1'b1;
          rsp_next.valid = !req_pf_reg;
          rsp_next.par_err = 1'b1;
          stall_next = req_pf_reg && !squash_reg;
          state_next = ST_IDLE;
        end else if (|c_hit) begin
          deliver = 1'b1;
          dlw = hit_lw;
          state_next = ST_IDLE;
        end else if (!out_reg) begin
          mrv_next = 1'b1;
          mra_next = {paddr_reg[31:`CFT_IDX_LO], 3'h0};
          out_next = 1'b1;
          vict_next = !c_rd[0].valid ? 1'b0 : (!c_rd[1].valid ? 1'b1 : lfsr_reg[0]);
          state_next = ST_MEM;
        end
      end
      ST_MEM: begin
        if (mem_rsp_valid) begin
          out_next = 1'b0;
          deliver = 1'b1;
          dlw = fill_lw;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (deliver) begin
      if (!req_pf_reg) begin
        rsp_next.valid = 1'b1;
        rsp_next.ok = 1'b1;
        rsp_next.data = dlw;
      end else if (!squash_reg) begin
        fill_en = 1'b1;
        lw = dlw;
      end
    end
    // Append fetched longword behind what remains
    if (fill_en) begin
      nb_i = `CFT_LW_BYTES - off_i;
      for (int i = 0; i < `CFT_IB_BYTES; i++) begin
        if (i >= cnt_i && i < cnt_i + nb_i) begin
          ibb_next[8*i +: 8] = lw[8*(i - cnt_i + off_i) +: 8];
        end
      end
      cnt_i = cnt_i + nb_i;
      pfa_next = pfa_reg + 32'h4;
      pfo_next = 2'h0;
    end
    ibc_next = `CFT_IB_CNT_W'(cnt_i);
    if (br_valid) begin
      ibb_next = 64'h0;
      ibc_next = 4'h0;
      ibv_next = 1'b0;
      pfa_next = {br_target[31:2], 2'h0};
      pfo_next = br_target[1:0];
      stall_next = 1'b0;
      squash_next = state_reg != ST_IDLE && state_reg != ST_INIT && req_pf_reg;
    end
    rdy_next = state_next == ST_IDLE;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_INIT;
      req_pf_reg <= 1'b0;
      squash_reg <= 1'b0;
      vaddr_reg <= 32'h0;
      paddr_reg <= 32'h0;
      init_reg <= 9'h000;
      lfsr_reg <= `CFT_LFSR_SEED;
      vict_reg <= 1'b0;
      out_reg <= 1'b0;
      mrv_reg <= 1'b0;
      mra_reg <= 32'h0;
      rdy_reg <= 1'b0;
      rsp_reg <= '0;
      ibb_reg <= 64'h0;
      ibc_reg <= 4'h0;
      ibv_reg <= 1'b0;
      ibd_reg <= 32'h0;
      pfa_reg <= 32'h0;
      pfo_reg <= 2'h0;
      stall_reg <= 1'b0;
      pfm_reg <= 1'b0;
      perr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_pf_reg <= req_pf_next;
      squash_reg <= squash_next;
      vaddr_reg <= vaddr_next;
      paddr_reg <= paddr_next;
      init_reg <= init_next;
      lfsr_reg <= lfsr_next;
      vict_reg <= vict_next;
      out_reg <= out_next;
      mrv_reg <= mrv_next;
      mra_reg <= mra_next;
      rdy_reg <= rdy_next;
      rsp_reg <= rsp_next;
      ibb_reg <= ibb_next;
      ibc_reg <= ibc_next;
      ibv_reg <= ibv_next;
      ibd_reg <= ibd_next;
      pfa_reg <= pfa_next;
      pfo_reg <= pfo_next;
      stall_reg <= stall_next;
      pfm_reg <= pfm_next;
      perr_reg <= perr_next;
    end
  end

  assign dp_req_ready = rdy_reg;
  assign dp_rsp = rsp_reg;
  assign ib_rsp_valid = ibv_reg;
  assign ib_rsp_data = ibd_reg;
  assign ib_level = ibc_reg;
  assign mem_rd_valid = mrv_reg;
  assign mem_rd_addr = mra_reg;
  assign pf_tb_miss = pfm_reg;
  assign par_err = perr_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_one_outstanding:
    assert property (mem_rd_valid |-> !$past(out_reg)) else $error("Second memory read while one outstanding");
  a_block_aligned:
    assert property (mem_rd_valid |-> mem_rd_addr[2:0] == 3'h0) else $error("Memory read not block aligned");
  a_alloc_read:
    assert property (|c_we |-> state_reg == ST_INIT || (state_reg == ST_MEM && mem_rsp_valid))
    else $error("Cache written outside a read fill");
  a_fill_installs:
    assert property ((state_reg == ST_MEM && mem_rsp_valid) |-> $onehot(c_we)) else $error("Fill not installed");
  a_ib_bound:
    assert property (ib_level <= 4'h8) else $error("Prefetch buffer overfilled");
  a_branch_flush:
    assert property (br_valid |=> ib_level == 4'h0 && pfa_reg[31:2] == $past(br_target[31:2]))
    else $error("Branch did not flush and redirect");
  a_squash_drop:
    assert property ((state_reg == ST_MEM && mem_rsp_valid && req_pf_reg && squash_reg && !ib_req && !br_valid)
      |=> ib_level == $past(ib_level)) else $error("Unwanted prefetch entered buffer");
  a_ib_answer:
    assert property ((ib_req && ib_req_len != 3'h0 && ib_req_len <= 3'h4 && 4'(ib_req_len) <= ib_level && !br_valid)
      |=> ib_rsp_valid && ib_rsp_data == $past(ibb_reg[31:0])) else $error("Buffer request not answered");
  a_tb_then_cache:
    assert property (state_reg == ST_CA |-> $past(state_reg) inside {ST_TB, ST_CA})
    else $error("Cache searched without translation");
  a_perr_no_ok:
    assert property (dp_rsp.par_err |-> !dp_rsp.ok && dp_rsp.valid) else $error("Faulty entry delivered");
endmodule // cft_front
`default_nettype wire

// *** core/cft_map.svh ***
// Address split, array sizes and timing-free constants of the memory front end
`ifndef CFT_MAP_SVH
`define CFT_MAP_SVH
`define CFT_ADDR_W 32
`define CFT_SETS 512
`define CFT_SET_W 9
`define CFT_IDX_LO 3
`define CFT_IDX_HI 11
`define CFT_TAG_LO 12
`define CFT_TAG_W 24
`define CFT_LINE_W 64
`define CFT_CPAR_W 11
`define CFT_WSEL_BIT 2
`define CFT_SPACE_BIT 31
`define CFT_PG_HI 8
`define CFT_TB_IDX_LO 9
`define CFT_TB_IDX_HI 13
`define CFT_TB_TAG_LO 14
`define CFT_TB_TAG_HI 30
`define CFT_TB_DEPTH 64
`define CFT_TB_AW 6
`define CFT_VTAG_W 17
`define CFT_PFN_W 23
`define CFT_TPAR_W 5
`define CFT_IB_BYTES 8
`define CFT_IB_CNT_W 4
`define CFT_LW_BYTES 4
`define CFT_LEN_W 3
`define CFT_LFSR_SEED 8'hA5
`define CFT_LFSR_TAPS 8'hB8
`endif

// *** core/cft_pkg.sv ***
// Types shared by the memory front end
`default_nettype none
`include "cft_map.svh"
package cft_pkg;
  typedef enum logic [4:0] {
    ST_INIT = 5'h01,
    ST_IDLE = 5'h02,
    ST_TB = 5'h04,
    ST_CA = 5'h08,
    ST_MEM = 5'h10
  } cft_state_t;

  typedef struct packed {
    logic valid;
    logic [`CFT_CPAR_W-1:0] par;
    logic [`CFT_TAG_W-1:0] tag;
    logic [`CFT_LINE_W-1:0] data;
  } cft_centry_t;

  typedef struct packed {
    logic valid;
    logic [`CFT_TPAR_W-1:0] par;
    logic [`CFT_VTAG_W-1:0] vtag;
    logic [`CFT_PFN_W-1:0] pfn;
  } cft_tentry_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic tb_miss;
    logic par_err;
    logic [31:0] data;
  } cft_dp_rsp_t;
endpackage
`default_nettype wire

// *** core/cft_ram.sv ***
// Single read, single write memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module cft_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // cft_ram
`default_nettype wire

// *** dv/cft_mem_model.sv ***
// Backplane memory model answering block reads after a set latency
`timescale 1ns/1ns
`default_nettype none
`include "cft_map.svh"
module cft_mem_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic mem_rd_valid,
  input wire logic [31:0] mem_rd_addr,
  input wire logic [7:0] lat,
  output logic mem_rsp_valid,
  output logic [`CFT_LINE_W-1:0] mem_rsp_data,
  output var int rd_count,
  output logic overlap
);
  logic pend;
  logic [7:0] cnt;
  logic [31:0] addr;
  int k;
  // Byte pattern derived from the byte address
  function automatic logic [7:0] mbyte(input logic [31:0] b);
    return b[7:0] ^ b[15:8] ^ 8'h3C;
  endfunction
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend <= 1'b0;
      cnt <= 8'h00;
      addr <= 32'h0000_0000;
      rd_count <= 0;
      overlap <= 1'b0;
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= 64'h0000_0000_0000_0000;
    end else begin
      mem_rsp_valid <= 1'b0;
      // Released data lines keep toggling
      mem_rsp_data <= ~mem_rsp_data;
      if (mem_rd_valid) begin
        overlap <= overlap | pend;
        pend <= 1'b1;
        cnt <= lat;
        addr <= mem_rd_addr;
        rd_count <= rd_count + 1;
      end else if (pend && cnt == 8'h00) begin
        pend <= 1'b0;
        mem_rsp_valid <= 1'b1;
        for (k = 0; k < 8; k++) begin
          mem_rsp_data[8*k +: 8] <= mbyte(addr + 32'(k));
        end
      end else if (pend) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule // cft_mem_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the memory front end
`timescale 1ns/1ns
`default_nettype none
`include "cft_map.svh"
module tb_top;
  import cft_pkg::*;
  logic clock, resetn, dp_req_valid, dp_req_ready, ib_req, ib_rsp_valid, br_valid, tb_wr_valid;
  logic mem_rd_valid, mem_rsp_valid, pf_tb_miss, par_err, overlap, perr_seen;
  logic [31:0] dp_req_vaddr, ib_rsp_data, br_target, tb_wr_vaddr, mem_rd_addr;
  logic [`CFT_LEN_W-1:0] ib_req_len;
  logic [`CFT_IB_CNT_W-1:0] ib_level;
  logic [`CFT_PFN_W-1:0] tb_wr_pfn;
  logic [`CFT_LINE_W-1:0] mem_rsp_data;
  logic [7:0] lat;
  cft_dp_rsp_t dp_rsp, rsp;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int rd_count, rc, w;
  cft_front cft_front_inst (.clock, .resetn, .dp_req_valid, .dp_req_vaddr, .dp_req_ready, .dp_rsp,
    .ib_req, .ib_req_len, .ib_rsp_valid, .ib_rsp_data, .ib_level, .br_valid, .br_target, .tb_wr_valid,
    .tb_wr_vaddr, .tb_wr_pfn, .mem_rd_valid, .mem_rd_addr, .mem_rsp_valid, .mem_rsp_data,
    .pf_tb_miss, .par_err);
  cft_mem_model cft_mem_model_inst (.clock, .resetn, .mem_rd_valid, .mem_rd_addr, .lat, .mem_rsp_valid,
    .mem_rsp_data, .rd_count, .overlap);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (par_err === 1'b1) perr_seen <= 1'b1;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  function automatic logic [7:0] mb(input logic [31:0] b);
    return b[7:0] ^ b[15:8] ^ 8'h3C;
  endfunction
  // Four bytes from byte address p, lowest address in bits 7:0
  function automatic logic [31:0] b4(input logic [31:0] p);
    return {mb(p + 32'h3), mb(p + 32'h2), mb(p + 32'h1), mb(p)};
  endfunction
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tload(input logic [31:0] va, input logic [22:0] pfn);
    @(negedge clock);
    tb_wr_valid = 1'b1;
    tb_wr_vaddr = va;
    tb_wr_pfn = pfn;
    @(negedge clock);
    tb_wr_valid = 1'b0;
  endtask
  task automatic dread(input logic [31:0] va);
    int n;
    n = 0;
    @(negedge clock);
    while (dp_req_ready !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    dp_req_valid = 1'b1;
    dp_req_vaddr = va;
    @(negedge clock);
    dp_req_valid = 1'b0;
    n = 0;
    while (dp_rsp.valid !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    rsp = dp_rsp;
    check("dp answer in time", 1'b1, n < 400);
  endtask
  task automatic ib_take(input logic [2:0] len);
    @(negedge clock);
    ib_req = 1'b1;
    ib_req_len = len;
    @(negedge clock);
    ib_req = 1'b0;
  endtask
  task automatic branch(input logic [31:0] t);
    @(negedge clock);
    br_valid = 1'b1;
    br_target = t;
    @(negedge clock);
    br_valid = 1'b0;
  endtask
  task automatic wait_level(input logic [3:0] lv);
    int n;
    n = 0;
    while (ib_level !== lv && n < 400) begin
      @(negedge clock);
      n++;
    end
    check("buffer level", lv, ib_level);
  endtask
  task automatic test_space;
    tload(32'h8000_0200, 23'h000100);
    dread(32'h0000_0208);
    check("process half miss", 1'b1, rsp.tb_miss);
    check("no data on miss", 1'b0, rsp.ok);
    dread(32'h8000_3E08);
    check("unloaded page miss", 1'b1, rsp.tb_miss);
    $display("test_space done");
  endtask
  task automatic test_fill;
    rc = rd_count;
    dread(32'h8000_0208);
    check("block address", 32'h0002_0008, mem_rd_addr);
    check("fill data", b4(32'h0002_0008), rsp.data);
    check("one block read", rc + 1, rd_count);
    dread(32'h8000_020C);
    check("resident half", b4(32'h0002_000C), rsp.data);
    check("no refetch", rc + 1, rd_count);
    $display("test_fill done");
  endtask
  task automatic test_replace;
    tload(32'h8000_0400, 23'h000108);
    tload(32'h8000_0600, 23'h000110);
    dread(32'h8000_0408);
    check("second way data", b4(32'h0002_1008), rsp.data);
    dread(32'h8000_0608);
    rc = rd_count;
    dread(32'h8000_0608);
    check("new block hits", rc, rd_count);
    dread(32'h8000_0208);
    dread(32'h8000_0408);
    check("one way evicted", 1'b1, rd_count - rc >= 1 && rd_count - rc <= 2);
    $display("test_replace done");
  endtask
  task automatic test_prefetch;
    tload(32'h0000_1000, 23'h000200);
    branch(32'h0000_1002);
    wait_level(4'h6);
    ib_take(3'h7);
    check("bad length refused", 1'b0, ib_rsp_valid);
    check("level kept", 4'h6, ib_level);
    ib_take(3'h4);
    check("straddle answer", 1'b1, ib_rsp_valid);
    check("straddle bytes", b4(32'h0004_0002), ib_rsp_data);
    check("level after take", 4'h2, ib_level);
    wait_level(4'h6);
    ib_take(3'h4);
    check("sequential bytes", b4(32'h0004_0006), ib_rsp_data);
    $display("test_prefetch done");
  endtask
  task automatic test_branch;
    int n;
    lat = 8'h1E;
    wait_level(4'h6);
    ib_take(3'h4);
    n = 0;
    while (mem_rd_valid !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    check("next block fetched", 32'h0004_0010, mem_rd_addr);
    branch(32'h0000_1100);
    check("flushed", 4'h0, ib_level);
    dread(32'h0000_1180);
    check("miss behind fetch", b4(32'h0004_0180), rsp.data);
    wait_level(4'h8);
    rc = rd_count;
    dread(32'h0000_1014);
    check("stale block data", b4(32'h0004_0014), rsp.data);
    check("stale block cached", rc, rd_count);
    ib_take(3'h4);
    check("target bytes", b4(32'h0004_0100), ib_rsp_data);
    check("no overlapping reads", 1'b0, overlap);
    branch(32'h0000_3000);
    n = 0;
    while (pf_tb_miss !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    check("prefetch page miss", 1'b1, pf_tb_miss);
    repeat (4) @(negedge clock);
    check("stalled empty", 4'h0, ib_level);
    $display("test_branch done");
  endtask
  task automatic end_of_test;
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    dp_req_valid = 1'b0;
    dp_req_vaddr = 32'h0000_0000;
    ib_req = 1'b0;
    ib_req_len = 3'h0;
    br_valid = 1'b0;
    br_target = 32'h0000_0000;
    tb_wr_valid = 1'b0;
    tb_wr_vaddr = 32'h0000_0000;
    tb_wr_pfn = 23'h000000;
    lat = 8'h02;
    perr_seen = 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    w = 0;
    while (dp_req_ready !== 1'b1 && w < 700) begin
      @(negedge clock);
      w++;
    end
    check("ready after clear", 1'b1, dp_req_ready);
    test_space();
    test_fill();
    test_replace();
    test_prefetch();
    test_branch();
    check("no parity errors", 1'b0, perr_seen);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
